// File: lcs_scheduler.sv
// Low-power background calibration scheduler: registers, trigger select and core sequencing
`timescale 1ns/1ps
`default_nettype none
`include "lcs_regs.svh"

module lcs_scheduler #(
    parameter int                            NUM_CORES = `LCS_NUM_CORES,
    parameter int                            CW        = `LCS_CNT_W,
    parameter int                            UNIT_CYC  = `LCS_UNIT_CYC,
    parameter logic [8*`LCS_EXP_W-1:0]       SLEEP_EXP = `LCS_SLEEP_EXP,
    parameter logic [4*`LCS_EXP_W-1:0]       WAKE_EXP  = `LCS_WAKE_EXP
) (
    input  wire logic                        clk,                      // 40 MHz device clock
    input  wire logic                        rst_b,                    // Async reset, active low
    input  wire logic                        reg_wr_en,                // Register write strobe
    input  wire logic                        reg_rd_en,                // Register read strobe
    input  wire logic [`LCS_ADDR_W-1:0]      reg_addr,                 // Register offset
    input  wire lcs_pkg::lcs_byte_t          reg_wdata,                // Write data
    output var  lcs_pkg::lcs_byte_t          reg_rdata,                // Read data, next cycle
    input  wire logic                        background_cal_enable,    // Background calibration on
    input  wire logic                        trigger_source_select,    // 1 selects pin trigger
    input  wire logic                        external_cal_trigger_pin, // Asynchronous trigger pin
    input  wire logic                        cal_done,                 // Calibration of core finished
    output var  logic [NUM_CORES-1:0]        core_sleep,               // Per-core sleep request
    output var  logic [$clog2(NUM_CORES)-1:0] core_sel,                // Core being scheduled
    output var  logic                        cal_req,                  // Calibrate selected core
    output var  logic                        cal_trigger,              // Selected trigger level
    output var  logic                        lowpower_active           // Low-power scheduling on
);
    import lcs_pkg::*;

    localparam int SW = $clog2(NUM_CORES);

    lcs_byte_t      soft_trig_r;
    lcs_byte_t      lp_ctrl_r;
    logic           pin_s1_r;
    logic           pin_s2_r;
    logic [7:0]     cfg_prev_r;
    lcs_state_t     state_r;
    lcs_state_t     state_nxt;
    logic [SW-1:0]  sel_nxt;

    lcs_cnt_if #(.CW(CW)) cif ();

    lcs_interval_counter #(.CW(CW)) u_cnt (
        .clk   (clk),
        .rst_b (rst_b),
        .cif   (cif)
    );

    function automatic logic [CW-1:0] span(input logic [`LCS_EXP_W-1:0] e);
        span = ((CW'(1) << e) + CW'(1)) * CW'(UNIT_CYC);
    endfunction

    // Register decode
    wire            wr_soft    = reg_wr_en && (reg_addr == `LCS_OFF_SOFT_TRIG);
    wire            wr_lp      = reg_wr_en && (reg_addr == `LCS_OFF_LP_CTRL);
    wire lcs_byte_t rd_mux     = (reg_addr == `LCS_OFF_SOFT_TRIG) ? soft_trig_r :
                                 (reg_addr == `LCS_OFF_LP_CTRL)   ? lp_ctrl_r   : 8'h00;

    // Control fields
    wire [2:0]      sleep_code = lp_ctrl_r[`LCS_SLEEP_HI:`LCS_SLEEP_LO];
    wire [1:0]      wake_code  = lp_ctrl_r[`LCS_WAKE_HI:`LCS_WAKE_LO];
    wire            trig_mode  = lp_ctrl_r[`LCS_TRIG_MODE_BIT];
    wire            lp_active  = lp_ctrl_r[`LCS_LOWPOWER_CAL_ENABLE_BIT] && background_cal_enable;
    wire [7:0]      cfg_now    = {sleep_code, wake_code, trig_mode, lp_ctrl_r[`LCS_LOWPOWER_CAL_ENABLE_BIT],
                                  background_cal_enable};
    wire            cfg_chg    = (cfg_now != cfg_prev_r);

    // Trigger selection
    wire            trig_now   = trigger_source_select ? pin_s2_r
                                 : soft_trig_r[`LCS_SOFT_TRIG_BIT];

    wire [CW-1:0]   sleep_cyc  = span(SLEEP_EXP[sleep_code*`LCS_EXP_W +: `LCS_EXP_W]);
    wire [CW-1:0]   wake_cyc   = span(WAKE_EXP[wake_code*`LCS_EXP_W +: `LCS_EXP_W]);
    wire            last_core  = (core_sel == SW'(NUM_CORES - 1));

    // Sequencing
    always_comb
    begin
        state_nxt = state_r;
        sel_nxt   = core_sel;
        if (!lp_active)
            state_nxt = LCS_ST_IDLE;
        else if (cfg_chg || state_r == LCS_ST_IDLE)
            state_nxt = LCS_ST_SLEEP;
        else
        begin
            case (state_r)
                LCS_ST_SLEEP:
                    if (trig_mode ? !trig_now : cif.done)
                        state_nxt = LCS_ST_WAKE;
                LCS_ST_WAKE:
                    if (cif.done)
                        state_nxt = LCS_ST_CAL;
                LCS_ST_CAL:
                    if (cal_done)
                    begin
                        state_nxt = LCS_ST_SLEEP;
                        sel_nxt   = last_core ? '0 : core_sel + SW'(1);
                    end
                default:
                    state_nxt = LCS_ST_IDLE;
            endcase
        end
    end

    // Sleep count is loaded only in autonomous mode
    assign cif.load = ((state_nxt == LCS_ST_SLEEP) && !trig_mode
                       && (state_r != LCS_ST_SLEEP || cfg_chg))
                      || ((state_nxt == LCS_ST_WAKE) && state_r != LCS_ST_WAKE);
    assign cif.val  = (state_nxt == LCS_ST_WAKE) ? wake_cyc : sleep_cyc;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            soft_trig_r <= `LCS_SOFT_TRIG_RST;
            lp_ctrl_r   <= `LCS_LP_CTRL_RST;
        end
        else
        begin
            if (wr_soft)
                soft_trig_r <= reg_wdata;
            if (wr_lp)
                lp_ctrl_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else if (reg_rd_en)
            reg_rdata <= rd_mux;
    end

    // Pin synchroniser
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end
        else
        begin
            pin_s1_r <= external_cal_trigger_pin;
            pin_s2_r <= pin_s1_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r         <= LCS_ST_IDLE;
            cfg_prev_r      <= 8'h00;
            core_sel        <= '0;
            cal_req         <= 1'b0;
            cal_trigger     <= 1'b1;
            lowpower_active <= 1'b0;
        end
        else
        begin
            state_r         <= state_nxt;
            cfg_prev_r      <= cfg_now;
            core_sel        <= sel_nxt;
            cal_req         <= (state_nxt == LCS_ST_CAL);
            cal_trigger     <= trig_now;
            lowpower_active <= lp_active;
        end
    end

    // Only the scheduled core sleeps
    genvar g;
    generate
        for (g = 0; g < NUM_CORES; g++)
        begin : g_sleep
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    core_sleep[g] <= 1'b0;
                else
                    core_sleep[g] <= (state_nxt == LCS_ST_SLEEP) && (sel_nxt == SW'(g));
            end
        end
    endgenerate

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_soft_src;
        !trigger_source_select |=> cal_trigger == $past(soft_trig_r[0]);
    endproperty
    a_soft_src: assert property (p_soft_src) else $error("soft trigger not used");

    property p_pin_src;
        trigger_source_select |=> cal_trigger == $past(pin_s2_r);
    endproperty
    a_pin_src: assert property (p_pin_src) else $error("pin trigger not used");

    property p_rd_lp;
        reg_rd_en && reg_addr == `LCS_OFF_LP_CTRL && !wr_lp |=> reg_rdata == $past(lp_ctrl_r);
    endproperty
    a_rd_lp: assert property (p_rd_lp) else $error("control readback wrong");

    property p_off_no_sleep;
        !lp_active |=> core_sleep == '0 && !cal_req && !lowpower_active;
    endproperty
    a_off_no_sleep: assert property (p_off_no_sleep) else $error("sleep while disabled");

    property p_trig_wake;
        state_r == LCS_ST_SLEEP && lp_active && trig_mode && !cfg_chg && !trig_now
            |=> state_r == LCS_ST_WAKE && core_sleep == '0;
    endproperty
    a_trig_wake: assert property (p_trig_wake) else $error("low trigger did not wake");

    property p_trig_hold;
        state_r == LCS_ST_SLEEP && lp_active && trig_mode && !cfg_chg && trig_now
            |=> state_r == LCS_ST_SLEEP;
    endproperty
    a_trig_hold: assert property (p_trig_hold) else $error("woke with trigger high");

    property p_auto_wake;
        state_r == LCS_ST_SLEEP && !trig_mode ##1 state_r == LCS_ST_WAKE
            |-> $past(cif.done);
    endproperty
    a_auto_wake: assert property (p_auto_wake) else $error("sleep ended early");

    property p_settle;
        state_r == LCS_ST_WAKE ##1 state_r == LCS_ST_CAL |-> $past(cif.done) && cal_req;
    endproperty
    a_settle: assert property (p_settle) else $error("calibration before settling");

    property p_restart;
        lp_active && cfg_chg |=> state_r == LCS_ST_SLEEP;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart on change");

    c_auto_cycle: cover property (state_r == LCS_ST_CAL && cal_done && !trig_mode);
    c_trig_wake: cover property (state_r == LCS_ST_SLEEP ##1 state_r == LCS_ST_WAKE && trig_mode);
    c_core_wrap: cover property (last_core && state_r == LCS_ST_CAL && cal_done);
endmodule // lcs_scheduler

`default_nettype wire

// File: lcs_regs.svh
// Register offsets, field positions, reset values and timing figures of the scheduler
`ifndef LCS_REGS_SVH
`define LCS_REGS_SVH

`define LCS_ADDR_W        8
`define LCS_DATA_W        8
`define LCS_OFF_SOFT_TRIG 8'h6C
`define LCS_OFF_LP_CTRL   8'h6E
`define LCS_SOFT_TRIG_RST 8'h01
`define LCS_LP_CTRL_RST   8'h88
`define LCS_SOFT_TRIG_BIT 0
`define LCS_SLEEP_HI      7
`define LCS_SLEEP_LO      5
`define LCS_WAKE_HI       4
`define LCS_WAKE_LO       3
`define LCS_TRIG_MODE_BIT 1
`define LCS_LOWPOWER_CAL_ENABLE_BIT     0
`define LCS_EXP_W         6
`define LCS_CNT_W         42
`define LCS_UNIT_CYC      256
`define LCS_SLEEP_EXP     {6'h21, 6'h1E, 6'h1B, 6'h18, 6'h15, 6'h12, 6'h0F, 6'h03}
`define LCS_WAKE_EXP      {6'h18, 6'h15, 6'h12, 6'h21}
`define LCS_NUM_CORES     3

`endif

// File: lcs_pkg.sv
// Types shared by the low-power calibration scheduler
`default_nettype none

package lcs_pkg;

    typedef enum logic [1:0] {
        LCS_ST_IDLE,
        LCS_ST_SLEEP,
        LCS_ST_WAKE,
        LCS_ST_CAL
    } lcs_state_t;

    typedef logic [7:0] lcs_byte_t;

endpackage // lcs_pkg

`default_nettype wire

// File: lcs_cnt_if.sv
// Load and done signals between the scheduler and its interval counter
`timescale 1ns/1ps
`default_nettype none

interface lcs_cnt_if #(
    parameter int CW = 42
);
    logic          load;
    logic [CW-1:0] val;
    logic          done;

    modport ctrl (output load, output val, input done);
    modport cnt  (input load, input val, output done);
endinterface

`default_nettype wire

// File: lcs_interval_counter.sv
// Loadable down counter that times one sleep or settling interval
`timescale 1ns/1ps
`default_nettype none

module lcs_interval_counter #(
    parameter int CW = 42
) (
    input  wire logic clk,     // Device clock
    input  wire logic rst_b,   // Asynchronous reset, active low
    lcs_cnt_if.cnt    cif      // Load value in, done out
);
    logic [CW-1:0] cnt_r;

    // Loading N makes done rise N cycles later
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_r <= '0;
        else if (cif.load)
            cnt_r <= cif.val - CW'(1);
        else if (cnt_r != '0)
            cnt_r <= cnt_r - CW'(1);
    end

    assign cif.done = (cnt_r == '0);
endmodule // lcs_interval_counter

`default_nettype wire

// File: lcs_scheduler_tb_top.sv
// Self-checking testbench of the low-power calibration scheduler
`timescale 1ns/1ps
`default_nettype none
`include "lcs_regs.svh"

module lcs_scheduler_tb_top;
    import lcs_pkg::*;

    // Short exponents keep every interval within a few hundred cycles
    localparam logic [47:0] SEXP = {6'h08, 6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01};
    localparam logic [23:0] WEXP = {6'h04, 6'h03, 6'h02, 6'h01};

    logic       clk   = 1'b0;
    logic       rst_b = 1'b0;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic [7:0] addr  = 8'h00;
    lcs_byte_t  wdata = 8'h00;
    lcs_byte_t  rdata;
    logic       bg    = 1'b0;
    logic       tss   = 1'b0;
    logic       pin   = 1'b1;
    logic       cal_done = 1'b0;
    logic [2:0] core_sleep;
    logic [1:0] core_sel;
    logic       cal_req;
    logic       cal_trigger;
    logic       lp_act;
    int         n_mismatch = 0;
    int         n_tests    = 0;

    lcs_scheduler #(
        .NUM_CORES (3),
        .UNIT_CYC  (1),
        .SLEEP_EXP (SEXP),
        .WAKE_EXP  (WEXP)
    ) u_lcs_scheduler (
        .clk                      (clk),
        .rst_b                    (rst_b),
        .reg_wr_en                (wr),
        .reg_rd_en                (rd),
        .reg_addr                 (addr),
        .reg_wdata                (wdata),
        .reg_rdata                (rdata),
        .background_cal_enable    (bg),
        .trigger_source_select    (tss),
        .external_cal_trigger_pin (pin),
        .cal_done                 (cal_done),
        .core_sleep               (core_sleep),
        .core_sel                 (core_sel),
        .cal_req                  (cal_req),
        .cal_trigger              (cal_trigger),
        .lowpower_active          (lp_act)
    );

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        n_tests++;
        if (got !== want)
        begin
            n_mismatch++;
            $display("[ERR] %0t ns: got %h, expected %h", $time, got, want);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(16'(rdata), 16'(e));
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        chk(16'({cal_trigger, lp_act, cal_req, core_sleep}), 16'h0020);
        rd_chk(`LCS_OFF_SOFT_TRIG, 8'h01);
        rd_chk(`LCS_OFF_LP_CTRL, 8'h88);
        rd_chk(8'h6D, 8'h00);
        wr_reg(`LCS_OFF_LP_CTRL, 8'hFE);
        rd_chk(`LCS_OFF_LP_CTRL, 8'hFE);
        wr_reg(`LCS_OFF_SOFT_TRIG, 8'hFE);
        rd_chk(`LCS_OFF_SOFT_TRIG, 8'hFE);
        wr_reg(8'h6D, 8'hFF);
        rd_chk(`LCS_OFF_LP_CTRL, 8'hFE);
        wr_reg(`LCS_OFF_LP_CTRL, 8'h88);
    endtask

    task automatic t_trigger();
        wait_cyc(3);
        chk(16'(cal_trigger), 16'h0000);
        @(posedge clk);
        tss <= 1'b1;
        wait_cyc(5);
        chk(16'(cal_trigger), 16'h0001);
        @(posedge clk);
        pin <= 1'b0;
        wait_cyc(5);
        chk(16'(cal_trigger), 16'h0000);
        @(posedge clk);
        tss <= 1'b0;
        pin <= 1'b1;
        wr_reg(`LCS_OFF_SOFT_TRIG, 8'h01);
        wait_cyc(3);
        chk(16'(cal_trigger), 16'h0001);
    endtask

    task automatic t_gate();
        wr_reg(`LCS_OFF_LP_CTRL, 8'h09);
        wait_cyc(5);
        chk(16'({lp_act, core_sleep}), 16'h0000);
        @(posedge clk);
        bg <= 1'b1;
        wait_cyc(3);
        chk(16'(lp_act), 16'h0001);
        @(posedge clk);
        bg <= 1'b0;
        wait_cyc(3);
        chk(16'({lp_act, core_sleep}), 16'h0000);
        @(posedge clk);
        bg <= 1'b1;
    endtask

    task automatic t_auto(input int s);
        int         ns;
        int         nw;
        logic [1:0] sel;
        ns = 0;
        nw = 0;
        wr_reg(`LCS_OFF_LP_CTRL, 8'h00);
        wr_reg(`LCS_OFF_LP_CTRL, 8'((s << 5) | ((s % 4) << 3) | 1));
        for (int k = 0; k < 1000 && cal_req !== 1'b1; k++)
        begin
            @(posedge clk);
            #1;
            if (core_sleep !== 3'b000)
                ns++;
            else if (ns > 0 && cal_req !== 1'b1)
                nw++;
            if (ns == 1 && nw == 0)
                chk(16'(core_sleep), 16'(3'b001 << core_sel));
        end
        chk(16'(ns), 16'((1 << SEXP[6*s +: 6]) + 1));
        chk(16'(nw), 16'((1 << WEXP[6*(s%4) +: 6]) + 1));
        sel = core_sel;
        @(posedge clk);
        cal_done <= 1'b1;
        @(posedge clk);
        cal_done <= 1'b0;
        #1 chk(16'({cal_req, core_sel}), 16'((sel + 1) % 3));
    endtask

    // A new sleep code written mid-sleep must restart the interval with the short count
    task automatic t_restart();
        wr_reg(`LCS_OFF_LP_CTRL, 8'h00);
        wr_reg(`LCS_OFF_LP_CTRL, 8'hE9);
        wait_cyc(20);
        wr_reg(`LCS_OFF_LP_CTRL, 8'h09);
        wait_cyc(3);
        chk(16'(core_sleep), 16'(3'b001 << core_sel));
        wait_cyc(1);
        chk(16'(core_sleep), 16'h0000);
    endtask

    task automatic t_trig_mode();
        wr_reg(`LCS_OFF_LP_CTRL, 8'h00);
        wr_reg(`LCS_OFF_LP_CTRL, 8'h0B);
        wait_cyc(40);
        chk(16'(core_sleep), 16'(3'b001 << core_sel));
        wr_reg(`LCS_OFF_SOFT_TRIG, 8'h00);
        wait_cyc(4);
        chk(16'(core_sleep), 16'h0000);
        wait_cyc(12);
        chk(16'(cal_req), 16'h0001);
        wr_reg(`LCS_OFF_SOFT_TRIG, 8'h01);
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_trigger();
        t_gate();
        for (int s = 0; s < 8; s++)
            t_auto(s);
        t_restart();
        t_trig_mode();
        close_out();
    end

    // Cuts a hang short well beyond the expected run of about 800 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out();
    end

endmodule // lcs_scheduler_tb_top

`default_nettype wire
